// ---- mgmt_station_model.sv ----
// station management model: single-cycle register write and read strobes
// assumes the block samples its strobes on the rising edge of i_mclk
`timescale 1ns/1ps

module mgmt_station_model (
  input  wire logic        i_mclk,
  output logic      [4:0]  o_reg_index,
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic      [15:0] o_reg_wdata
);

  initial begin
    o_reg_index = 5'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access: a leading edge keeps two strobes from landing in one time step
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] data);
    @(posedge i_mclk);
    #1;
    o_reg_index = idx;
    o_reg_wdata = data;
    o_reg_wr    = wr;
    o_reg_rd    = ~wr;
    @(posedge i_mclk);
    #1;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    // released lines carry junk so a stale value never passes for a request
    o_reg_index = ~o_reg_index;
    o_reg_wdata = ~o_reg_wdata;
  endtask

endmodule

// ---- phy_irq_status_advreg_access.sv ----
// interrupt flags and mask, special status and the indirect advanced register read path
// assumes a management engine on i_mclk issuing one-cycle read and write strobes,
// and status sources and counters on the same clock
//
// Summary of operation
// - tx elastic overflow sets flag 10, underflow sets flag 9
// - idle error counter overflow sets flag 8
// - energy present rising from 0 to 1 sets flag 7
// - autoneg completion sets flag 6, partner acknowledge sets flag 3
// - remote fault sets flag 5, link going down sets flag 4
// - parallel detection fault or master/slave config fault sets flag 2
// - a received autoneg page sets flag 1
// - flags reset to 0, stay latched until cleared by writing one
// - flag bits 15:11 and bit 0 are reserved, read zero
// - mask bits 10:1 are read/write enables, 1 enables, reset 0
// - special status bit 12 shows autoneg done
// - reading special status clears nothing
// - special status bits 4:2 encode resolved speed and duplex
// - speed and duplex field loads from the autoneg outcome
// - after that write the selected contents appear at the data port
// - advanced registers take no writes; bits are read-only or read-clear
// - U0,U1 user status; U2-U4 good packet counter high, mid, low
// - U5-U7 crc counter high, mid, low; U8 data errors; U9 idle errors
// - U10-U12 transmit packet counter high, mid, low
// - read bit 15 self-clears; address 6:0 selects 0..12; bits 14:7 stored
// - data port is read-only at index 21, resets to zero
// - counters read low, mid, high; reading high clears the whole counter
`timescale 1ns/1ps

module phy_irq_status_advreg_access
  import phy_mgmt_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // management register access
  input  wire logic [4:0]  i_reg_index,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_rvalid,
  // interrupt event sources
  input  wire logic        i_tx_elastic_overflow,
  input  wire logic        i_tx_elastic_underflow,
  input  wire logic        i_idle_error_overflow,
  input  wire logic        i_energy_present,
  input  wire logic        i_autoneg_done,
  input  wire logic        i_remote_fault,
  input  wire logic        i_link_up,
  input  wire logic        i_partner_ack,
  input  wire logic        i_parallel_detect_fault,
  input  wire logic        i_ms_config_fault,
  input  wire logic        i_page_received,
  input  wire logic [2:0]  i_resolved_speed_duplex,
  output logic             o_irq,
  // advanced register sources
  input  wire logic [15:0] i_user_status1,
  input  wire logic [15:0] i_user_status2,
  input  wire logic [47:0] i_rx_good_count,
  input  wire logic [47:0] i_crc_error_count,
  input  wire logic [15:0] i_rx_error_data_count,
  input  wire logic [15:0] i_rx_error_idle_count,
  input  wire logic [47:0] i_tx_packet_count,
  output logic             o_rx_good_clear,
  output logic             o_crc_error_clear,
  output logic             o_tx_packet_clear
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] mask_q;
  logic [2:0]  speed_q;
  logic        an_done_q;
  logic        energy_prev_q;
  logic        link_prev_q;
  logic [7:0]  adv_rsv_q;
  logic [6:0]  adv_addr_q;
  logic [15:0] adv_data_q;
  logic [15:0] set_vec;
  logic        wr_flags;
  logic        wr_adv_addr;
  logic        adv_read_req;
  logic [6:0]  adv_sel;

  function automatic logic rising(input logic now, input logic prev);
    rising = now & ~prev;
  endfunction

  function automatic logic [15:0] adv_mux(
    input logic [6:0]  sel,
    input logic [15:0] u1,
    input logic [15:0] u2,
    input logic [47:0] good,
    input logic [47:0] crc,
    input logic [15:0] edata,
    input logic [15:0] eidle,
    input logic [47:0] tx
  );
    case (sel)
      ADV_USER1:      adv_mux = u1;
      ADV_USER2:      adv_mux = u2;
      ADV_RXGOOD_HI:  adv_mux = good[47:32];
      ADV_RXGOOD_MID: adv_mux = good[31:16];
      ADV_RXGOOD_LO:  adv_mux = good[15:0];
      ADV_CRC_HI:     adv_mux = crc[47:32];
      ADV_CRC_MID:    adv_mux = crc[31:16];
      ADV_CRC_LO:     adv_mux = crc[15:0];
      ADV_RXERR_DATA: adv_mux = edata;
      ADV_RXERR_IDLE: adv_mux = eidle;
      ADV_TXPKT_HI:   adv_mux = tx[47:32];
      ADV_TXPKT_MID:  adv_mux = tx[31:16];
      ADV_TXPKT_LO:   adv_mux = tx[15:0];
      default:        adv_mux = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags

  always_comb begin
    set_vec                  = 16'h0000;
    set_vec[BIT_TX_OVF]      = i_tx_elastic_overflow;
    set_vec[BIT_TX_UNF]      = i_tx_elastic_underflow;
    set_vec[BIT_IDLE_OVF]    = i_idle_error_overflow;
    set_vec[BIT_ENERGY]      = rising(i_energy_present, energy_prev_q);
    set_vec[BIT_AN_DONE]     = rising(i_autoneg_done, an_done_q);
    set_vec[BIT_REMOTE_FLT]  = i_remote_fault;
    set_vec[BIT_LINK_DOWN]   = rising(link_prev_q, i_link_up);
    set_vec[BIT_PARTNER_ACK] = i_partner_ack;
    set_vec[BIT_CFG_FAULT]   = i_parallel_detect_fault | i_ms_config_fault;
    set_vec[BIT_PAGE_RX]     = i_page_received;
  end

  assign wr_flags = i_reg_wr & (i_reg_index == IDX_INT_FLAGS);

  // a new event beats a clear in the same cycle so no cause is lost
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_d & ~i_reg_wdata;
    end
    flags_d = (flags_d | set_vec) & FLAG_IMPL_MASK;
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_q <= FLAG_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_q <= MASK_RESET;
    end else if (i_reg_wr && i_reg_index == IDX_INT_MASK) begin
      mask_q <= i_reg_wdata & FLAG_IMPL_MASK;
    end
  end

  assign o_irq = |(flags_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // source history and special status

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      energy_prev_q <= 1'b0;
      link_prev_q   <= 1'b0;
      an_done_q     <= 1'b0;
    end else begin
      energy_prev_q <= i_energy_present;
      link_prev_q   <= i_link_up;
      an_done_q     <= i_autoneg_done;
    end
  end

  // held between negotiations so software sees the last outcome
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      speed_q <= SPD_RESET;
    end else if (rising(i_autoneg_done, an_done_q)) begin
      speed_q <= i_resolved_speed_duplex;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // advanced register access

  assign wr_adv_addr  = i_reg_wr & (i_reg_index == IDX_ADV_ADDR);
  assign adv_read_req = wr_adv_addr & i_reg_wdata[BIT_ADV_READ];
  assign adv_sel      = i_reg_wdata[ADV_W-1:0];

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adv_rsv_q  <= ADV_RSV_RESET;
      adv_addr_q <= ADV_ADDR_RESET;
    end else if (wr_adv_addr) begin
      adv_rsv_q  <= i_reg_wdata[ADV_RSV_MSB:ADV_RSV_LSB];
      adv_addr_q <= adv_sel;
    end
  end

  // index 21 has no write path at all
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      adv_data_q <= ADV_DATA_RESET;
    end else if (adv_read_req) begin
      adv_data_q <= adv_mux(adv_sel, i_user_status1, i_user_status2,
                            i_rx_good_count, i_crc_error_count,
                            i_rx_error_data_count, i_rx_error_idle_count,
                            i_tx_packet_count);
    end
  end

  // the high part is latched before the clear lands, so the value read is intact
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rx_good_clear   <= 1'b0;
      o_crc_error_clear <= 1'b0;
      o_tx_packet_clear <= 1'b0;
    end else begin
      o_rx_good_clear   <= adv_read_req && adv_sel == ADV_RXGOOD_HI;
      o_crc_error_clear <= adv_read_req && adv_sel == ADV_CRC_HI;
      o_tx_packet_clear <= adv_read_req && adv_sel == ADV_TXPKT_HI;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_index)
          IDX_ADV_ADDR:  o_reg_rdata <= {1'b0, adv_rsv_q, adv_addr_q};
          IDX_ADV_DATA:  o_reg_rdata <= adv_data_q;
          IDX_INT_FLAGS: o_reg_rdata <= flags_q;
          IDX_INT_MASK:  o_reg_rdata <= mask_q;
          IDX_SPECIAL: begin
            o_reg_rdata                  <= 16'h0000;
            o_reg_rdata[BIT_SPC_AN_DONE] <= an_done_q;
            o_reg_rdata[SPD_MSB:SPD_LSB] <= speed_q;
          end
          default:       o_reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  sequence adv_write_s(logic [6:0] num);
    wr_adv_addr && i_reg_wdata[BIT_ADV_READ] && i_reg_wdata[ADV_W-1:0] == num;
  endsequence

  sequence data_read_s;
    i_reg_rd && i_reg_index == IDX_ADV_DATA;
  endsequence

  tx_overflow_set_a: assert property (i_tx_elastic_overflow |=> flags_q[BIT_TX_OVF])
    else $error("overflow event did not set its flag");
  tx_underflow_set_a: assert property (i_tx_elastic_underflow |=> flags_q[BIT_TX_UNF])
    else $error("underflow event did not set its flag");
  idle_ovf_set_a: assert property (i_idle_error_overflow |=> flags_q[BIT_IDLE_OVF])
    else $error("idle overflow did not set its flag");
  energy_rise_set_a: assert property (
    !i_energy_present ##1 i_energy_present |=> flags_q[BIT_ENERGY])
    else $error("energy rising edge did not set its flag");
  energy_no_fall_a: assert property (
    !i_energy_present && energy_prev_q
    |-> set_vec[BIT_ENERGY] == 1'b0)
    else $error("energy flag set on a falling edge");
  autoneg_set_a: assert property (
    !i_autoneg_done ##1 i_autoneg_done |=> flags_q[BIT_AN_DONE])
    else $error("autoneg completion did not set its flag");
  partner_ack_set_a: assert property (i_partner_ack |=> flags_q[BIT_PARTNER_ACK])
    else $error("partner acknowledge did not set its flag");
  remote_fault_set_a: assert property (i_remote_fault |=> flags_q[BIT_REMOTE_FLT])
    else $error("remote fault did not set its flag");
  link_down_set_a: assert property (i_link_up ##1 !i_link_up |=> flags_q[BIT_LINK_DOWN])
    else $error("link drop did not set its flag");
  cfg_fault_set_a: assert property (
    (i_parallel_detect_fault || i_ms_config_fault) |=> flags_q[BIT_CFG_FAULT])
    else $error("config fault did not set its flag");
  page_rx_set_a: assert property (i_page_received |=> flags_q[BIT_PAGE_RX])
    else $error("page reception did not set its flag");
  flag_latch_a: assert property (
    (flags_q & ~$past(flags_q) & ~$past(set_vec)) == 16'h0000
    && ($past(flags_q) & ~flags_q & ~($past(wr_flags) ? $past(i_reg_wdata) : 16'h0000)) == 16'h0000)
    else $error("flag changed without an event or a clear");
  flag_clear_a: assert property (
    wr_flags && i_reg_wdata[BIT_PAGE_RX] && !i_page_received |=> !flags_q[BIT_PAGE_RX])
    else $error("write-one did not clear the flag");
  flag_reserved_a: assert property (
    i_reg_rd && i_reg_index == IDX_INT_FLAGS |=> (o_reg_rdata & ~FLAG_IMPL_MASK) == 16'h0000)
    else $error("reserved flag bits read nonzero");
  mask_write_a: assert property (
    i_reg_wr && i_reg_index == IDX_INT_MASK ##1 !i_reg_wr ##1 i_reg_rd && i_reg_index == IDX_INT_MASK && !i_reg_wr
    |=> o_reg_rdata == ($past(i_reg_wdata, 3) & FLAG_IMPL_MASK))
    else $error("mask read back differs from write");
  irq_level_a: assert property (o_irq == ((flags_q & mask_q) != 16'h0000))
    else $error("interrupt output disagrees with flags and mask");
  irq_masked_a: assert property (mask_q == 16'h0000 |-> !o_irq)
    else $error("interrupt raised with all sources masked");
  special_done_a: assert property (
    i_reg_rd && i_reg_index == IDX_SPECIAL |=> o_reg_rdata[BIT_SPC_AN_DONE] == $past(an_done_q))
    else $error("special status done bit wrong");
  special_no_clear_a: assert property (
    i_reg_rd && i_reg_index == IDX_SPECIAL && !i_reg_wr && set_vec == 16'h0000
    |=> flags_q == $past(flags_q) && speed_q == $past(speed_q))
    else $error("special status read disturbed state");
  speed_load_a: assert property (
    !i_autoneg_done ##1 i_autoneg_done |=> speed_q == $past(i_resolved_speed_duplex))
    else $error("speed field not loaded at autoneg done");
  speed_hold_a: assert property (!(i_autoneg_done && !an_done_q) |=> $stable(speed_q))
    else $error("speed field moved without a negotiation");
  adv_latch_a: assert property (
    adv_write_s(ADV_USER1) ##1 !wr_adv_addr ##1 data_read_s
    |=> o_reg_rdata == $past(i_user_status1, 3))
    else $error("user status not returned at data port");
  adv_crc_lo_a: assert property (
    adv_write_s(ADV_CRC_LO) |=> adv_data_q == $past(i_crc_error_count[15:0]))
    else $error("crc low part not latched");
  adv_tx_mid_a: assert property (
    adv_write_s(ADV_TXPKT_MID) |=> adv_data_q == $past(i_tx_packet_count[31:16]))
    else $error("tx mid part not latched");
  adv_nowrite_a: assert property (
    i_reg_wr && i_reg_index == IDX_ADV_DATA && !adv_read_req |=> $stable(adv_data_q))
    else $error("data port took a write");
  adv_range_a: assert property (
    adv_read_req && adv_sel > ADV_TXPKT_LO |=> adv_data_q == 16'h0000)
    else $error("out of range advanced number returned data");
  read_bit_clear_a: assert property (
    adv_read_req ##4 i_reg_rd && i_reg_index == IDX_ADV_ADDR |=> !o_reg_rdata[BIT_ADV_READ])
    else $error("read bit did not self-clear");
  hi_read_clear_a: assert property (
    adv_write_s(ADV_RXGOOD_HI) |=> o_rx_good_clear ##1 !o_rx_good_clear)
    else $error("good packet counter not cleared once");
  lo_no_clear_a: assert property (
    wr_adv_addr && adv_sel != ADV_CRC_HI |=> !o_crc_error_clear)
    else $error("crc counter cleared on a non-high read");

endmodule

// ---- phy_mgmt_pkg.sv ----
// constants for the interrupt, special status and advanced register block
// assumes a 16-bit management register space indexed by a 5-bit number
package phy_mgmt_pkg;

  localparam int          REG_W            = 16;
  localparam int          IDX_W            = 5;
  localparam int          ADV_W            = 7;
  localparam int          CNT_W            = 48;

  // management register indices
  localparam logic [4:0]  IDX_ADV_ADDR     = 5'h14;
  localparam logic [4:0]  IDX_ADV_DATA     = 5'h15;
  localparam logic [4:0]  IDX_INT_FLAGS    = 5'h1d;
  localparam logic [4:0]  IDX_INT_MASK     = 5'h1e;
  localparam logic [4:0]  IDX_SPECIAL      = 5'h1f;

  // interrupt flag positions
  localparam int          BIT_TX_OVF       = 10;
  localparam int          BIT_TX_UNF       = 9;
  localparam int          BIT_IDLE_OVF     = 8;
  localparam int          BIT_ENERGY       = 7;
  localparam int          BIT_AN_DONE      = 6;
  localparam int          BIT_REMOTE_FLT   = 5;
  localparam int          BIT_LINK_DOWN    = 4;
  localparam int          BIT_PARTNER_ACK  = 3;
  localparam int          BIT_CFG_FAULT    = 2;
  localparam int          BIT_PAGE_RX      = 1;
  localparam logic [15:0] FLAG_IMPL_MASK   = 16'h07fe;
  localparam logic [15:0] FLAG_RESET       = 16'h0000;
  localparam logic [15:0] MASK_RESET       = 16'h0000;

  // special status fields
  localparam int          BIT_SPC_AN_DONE  = 12;
  localparam int          SPD_LSB          = 2;
  localparam int          SPD_MSB          = 4;
  localparam logic [2:0]  SPD_RESET        = 3'h0;

  // advanced address port fields
  localparam int          BIT_ADV_READ     = 15;
  localparam int          ADV_RSV_LSB      = 7;
  localparam int          ADV_RSV_MSB      = 14;
  localparam logic [7:0]  ADV_RSV_RESET    = 8'h00;
  localparam logic [6:0]  ADV_ADDR_RESET   = 7'h00;
  localparam logic [15:0] ADV_DATA_RESET   = 16'h0000;

  // advanced register numbers
  localparam logic [6:0]  ADV_USER1        = 7'h00;
  localparam logic [6:0]  ADV_USER2        = 7'h01;
  localparam logic [6:0]  ADV_RXGOOD_HI    = 7'h02;
  localparam logic [6:0]  ADV_RXGOOD_MID   = 7'h03;
  localparam logic [6:0]  ADV_RXGOOD_LO    = 7'h04;
  localparam logic [6:0]  ADV_CRC_HI       = 7'h05;
  localparam logic [6:0]  ADV_CRC_MID      = 7'h06;
  localparam logic [6:0]  ADV_CRC_LO       = 7'h07;
  localparam logic [6:0]  ADV_RXERR_DATA   = 7'h08;
  localparam logic [6:0]  ADV_RXERR_IDLE   = 7'h09;
  localparam logic [6:0]  ADV_TXPKT_HI     = 7'h0a;
  localparam logic [6:0]  ADV_TXPKT_MID    = 7'h0b;
  localparam logic [6:0]  ADV_TXPKT_LO     = 7'h0c;

endpackage

// ---- test_phy_irq_status_advreg_access.sv ----
// self-checking bench for the interrupt, special status and advanced read block
// assumes the station model drives the register strobes; reads are checked from a queue
`timescale 1ns/1ps

module test_phy_irq_status_advreg_access;
  import phy_mgmt_pkg::*;

  localparam logic [10:0] SRC_IDLE  = 11'h040;
  localparam int          BITPOS [11] = '{BIT_TX_OVF, BIT_TX_UNF, BIT_IDLE_OVF, BIT_ENERGY, BIT_AN_DONE,
                                          BIT_REMOTE_FLT, BIT_LINK_DOWN, BIT_PARTNER_ACK, BIT_CFG_FAULT,
                                          BIT_CFG_FAULT, BIT_PAGE_RX};
  localparam logic [2:0]  SPEEDS [4]  = '{3'h1, 3'h5, 3'h2, 3'h6};
  localparam int          ORDER [14]  = '{0, 1, 4, 3, 2, 7, 6, 5, 8, 9, 12, 11, 10, 13};

  logic        i_mclk;
  logic        i_reset_n;
  logic [4:0]  reg_index;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic [10:0] src;
  logic [2:0]  speed;
  logic        irq;
  logic [15:0] u1, u2, edata, eidle, mask;
  logic [47:0] good, crc, tx;
  logic        good_clr, crc_clr, tx_clr;
  logic [15:0] exp_q[$];
  int          err_count;
  int          tests_run;

  mgmt_station_model mgmt_station_model_i (.i_mclk(i_mclk), .o_reg_index(reg_index), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));

  phy_irq_status_advreg_access phy_irq_status_advreg_access_i (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_index(reg_index), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .i_tx_elastic_overflow(src[0]), .i_tx_elastic_underflow(src[1]), .i_idle_error_overflow(src[2]),
    .i_energy_present(src[3]), .i_autoneg_done(src[4]), .i_remote_fault(src[5]), .i_link_up(src[6]),
    .i_partner_ack(src[7]), .i_parallel_detect_fault(src[8]), .i_ms_config_fault(src[9]),
    .i_page_received(src[10]), .i_resolved_speed_duplex(speed), .o_irq(irq),
    .i_user_status1(u1), .i_user_status2(u2), .i_rx_good_count(good), .i_crc_error_count(crc),
    .i_rx_error_data_count(edata), .i_rx_error_idle_count(eidle), .i_tx_packet_count(tx),
    .o_rx_good_clear(good_clr), .o_crc_error_clear(crc_clr), .o_tx_packet_clear(tx_clr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    mgmt_station_model_i.access(1'b1, idx, d);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [15:0] e);
    exp_q.push_back(e);
    mgmt_station_model_i.access(1'b0, idx, 16'h0000);
  endtask

  function automatic logic [15:0] adv_exp(input int n);
    case (n)
      0: return u1;
      1: return u2;
      2: return good[47:32];
      3: return good[31:16];
      4: return good[15:0];
      5: return crc[47:32];
      6: return crc[31:16];
      7: return crc[15:0];
      8: return edata;
      9: return eidle;
      10: return tx[47:32];
      11: return tx[31:16];
      12: return tx[15:0];
      default: return 16'h0000;
    endcase
  endfunction

  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // rvalid stands one cycle, so it is seen at exactly one rising edge
  always @(posedge i_mclk) begin
    if (reg_rvalid === 1'b1) begin
      check(reg_rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx);
    end
  end

  initial begin
    #2_000_000;
    err_count++;
    results();
  end

  initial begin
    i_reset_n = 1'b0;
    src       = SRC_IDLE;
    speed     = 3'h0;
    err_count = 0;
    tests_run = 0;
    void'($urandom(32'h6e59874a));
    u1    = 16'($urandom());
    u2    = 16'($urandom());
    edata = 16'($urandom());
    eidle = 16'($urandom());
    good  = 48'({$urandom(), $urandom()});
    crc   = 48'({$urandom(), $urandom()});
    tx    = 48'({$urandom(), $urandom()});
    repeat (10) @(posedge i_mclk);
    #1;
    i_reset_n = 1'b1;
    rd(IDX_INT_FLAGS, FLAG_RESET);
    rd(IDX_INT_MASK, MASK_RESET);
    rd(IDX_SPECIAL, 16'h0000);
    rd(IDX_ADV_ADDR, 16'h0000);
    rd(IDX_ADV_DATA, ADV_DATA_RESET);
    rd(5'h03, 16'h0000);
    wr(IDX_INT_MASK, 16'hffff);
    rd(IDX_INT_MASK, FLAG_IMPL_MASK);
    // every source alone, under a random mask
    for (int k = 0; k < 11; k++) begin
      mask = 16'($urandom()) & FLAG_IMPL_MASK;
      wr(IDX_INT_MASK, mask);
      src = SRC_IDLE ^ (11'h001 << k);
      @(posedge i_mclk);
      #1;
      src = SRC_IDLE;
      wr(IDX_INT_FLAGS, ~(16'h0001 << BITPOS[k]));
      rd(IDX_INT_FLAGS, 16'h0001 << BITPOS[k]);
      check({15'h0, irq}, {15'h0, mask[BITPOS[k]]});
      wr(IDX_INT_FLAGS, 16'h0001 << BITPOS[k]);
      check({15'h0, irq}, 16'h0000);
      rd(IDX_INT_FLAGS, 16'h0000);
    end
    // speed is latched only on the done rising edge
    for (int c = 0; c < 4; c++) begin
      speed  = SPEEDS[c];
      src[4] = 1'b1;
      rd(IDX_SPECIAL, 16'h1000 | (16'(SPEEDS[c]) << SPD_LSB));
      rd(IDX_SPECIAL, 16'h1000 | (16'(SPEEDS[c]) << SPD_LSB));
      speed  = ~SPEEDS[c];
      src[4] = 1'b0;
      rd(IDX_SPECIAL, 16'(SPEEDS[c]) << SPD_LSB);
    end
    wr(IDX_SPECIAL, 16'hffff);
    rd(IDX_SPECIAL, 16'(SPEEDS[3]) << SPD_LSB);
    wr(IDX_INT_FLAGS, 16'hffff);
    // counters read low, mid, high; high read fires the clear
    for (int i = 0; i < 14; i++) begin
      wr(IDX_ADV_ADDR, {1'b1, 8'h03, 7'(ORDER[i])});
      check({13'h0, good_clr, crc_clr, tx_clr}, {13'h0, ORDER[i] == 2, ORDER[i] == 5, ORDER[i] == 10});
      rd(IDX_ADV_DATA, adv_exp(ORDER[i]));
      rd(IDX_ADV_ADDR, {1'b0, 8'h03, 7'(ORDER[i])});
      wr(IDX_ADV_DATA, ~adv_exp(ORDER[i]));
      rd(IDX_ADV_DATA, adv_exp(ORDER[i]));
    end
    repeat (4) @(posedge i_mclk);
    check(16'(exp_q.size()), 16'h0000);
    results();
  end

endmodule
